/* File: shared/ubdma_pkg.sv */
// Purpose: constants, carriers and states of the bulk endpoint dma port
// Assumes: one 10 MHz clock; register offsets below are local choices
// Notes:   all widths in bits, all times in ns except REQ_EN_RAW and REQ_ENABLE_CYCLES in clock cycles
package ubdma_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_POLARITY = 8'h30;
  localparam logic [7:0] ADDR_CONTROL  = 8'h31;
  localparam logic [7:0] ADDR_INTERVAL = 8'h32;
  localparam logic [7:0] ADDR_STATUS   = 8'h33;
  localparam logic [7:0] ADDR_FIFO     = 8'h34;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int POL_DMA_REQUEST_OUT_BIT = 1;
  localparam int POL_DMA_ACKNOWLEDGE_IN_BIT = 2;
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_DUAL     = 1;
  localparam int CTL_COUNT    = 2;
  localparam int CTL_WIDE     = 3;
  localparam int CTL_DEMAND   = 4;
  localparam int CTL_PAUSE    = 7;
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [6:0] MAX_PACKET   = 7'h40;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS   = 84;
  localparam int REQ_ENABLE_NS = 100;
  localparam int REQ_EN_RAW    =
    (REQ_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] REQ_ENABLE_CYCLES =
    16'((REQ_EN_RAW < 1) ? 1 : REQ_EN_RAW);

  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       dir_in;     // 1: device to host
    logic       tx_space;   // transmit fifo can accept data
    logic       tx_acked;   // pulse: packet sent and acknowledged
    logic       tx_mcu_set; // pulse: processor marks short packet ready
    logic       rx_good;    // pulse: good packet received and acked
    logic [6:0] rx_count;   // byte count of that packet
    logic [7:0] rx_head_lo; // show-ahead fifo byte 0
    logic [7:0] rx_head_hi; // show-ahead fifo byte 1
  } ubdma_ep_in_t;

  typedef struct packed {
    logic        tx_ready;
    logic        rx_ready;
    logic        tx_push;
    logic        tx_two;
    logic [15:0] tx_data;
    logic        rx_pop;
    logic        rx_two;
    logic        rx_drained;
  } ubdma_ep_out_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } ubdma_bus_t;

endpackage : ubdma_pkg

/* File: design/ubdma_port.sv */
// Purpose: parallel bus attachment and dma request logic, bulk endpoint
// Assumes: endpoint fifo and flags of the unit sit on the same clock
// Notes:   pins pass two flip-flops before any logic reads them
// Operation
// - format select low: address from dedicated pins, data on low lines.
// - format select high: address and data share low lines.
// - multiplexed: latch address and chip select on falling latch strobe.
// - separate bus: latch strobe is ignored.
// - dma service only for bulk endpoint one.
// - request polarity bit 1: 0 active low, 1 active high.
// - acknowledge polarity bit 2: 0 active high, 1 active low.
// - transmit: request while fifo accepts; drop when packet ready set.
// - after host acks, clear transmit ready and request again.
// - good packet received: set receive ready and request.
// - all read out: clear receive ready, drop request.
// - enable bit 0 low keeps request inactive.
// - control bit 1: 0 acknowledge selects fifo, 1 ignore acknowledge.
// - control bit 4 picks single or demand transfer.
// - single mode drops request after each transfer.
// - demand mode holds request until packet data moved.
// - control bit 2 inserts byte count first, upper byte zero.
// - control bit 3 picks 8 or 16 bit, little endian lanes.
// - odd count in 16 bit: last upper byte zero.
// - single mode gap is enable time plus n times 84 ns.
// - max size packet written by dma sets transmit ready.
`timescale 1ns/10ps
`default_nettype none
module ubdma_port
  import ubdma_pkg::*;
#(
  parameter logic [6:0] MAX_PKT = MAX_PACKET
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          sw_reset,
  input  wire logic          bus_format_select,
  input  wire logic [7:0]    dedicated_address_pins,
  input  wire logic [7:0]    shared_low_byte_lines_in,
  output var  logic [7:0]    shared_low_byte_lines_out,
  output var  logic          shared_low_byte_lines_oe_n,
  input  wire logic [7:0]    upper_data_lines_in,
  output var  logic [7:0]    upper_data_lines_out,
  output var  logic          upper_data_lines_oe_n,
  input  wire logic          chip_select_n,
  input  wire logic          read_n,
  input  wire logic          write_n,
  input  wire logic          address_latch,
  input  wire logic          dma_acknowledge_in,
  output var  logic          dma_request_out,
  input  wire ubdma_ep_in_t  ep_in,
  output var  ubdma_ep_out_t ep_out
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = 30;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic          s_cs_n, s_rd_n, s_wr_n, s_ale, s_dma_acknowledge_in, s_fmt;
  logic [7:0]    s_addr, s_lo, s_hi;

  // strobes idle high under reset so no phantom cycle starts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {chip_select_n, read_n, write_n, address_latch,
                dma_acknowledge_in, bus_format_select,
                dedicated_address_pins, shared_low_byte_lines_in,
                upper_data_lines_in};
      sync2 <= sync1;
    end
  end

  assign {s_cs_n, s_rd_n, s_wr_n, s_ale, s_dma_acknowledge_in, s_fmt,
          s_addr, s_lo, s_hi} = sync2;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // gap after a single transfer, least time so rounded up
  function automatic logic [8:0] gap_cycles(input logic [7:0] n);
    logic [15:0] ns;
    ns = {8'h00, n} * 16'(BIT_TIME_NS);
    return 9'(REQ_ENABLE_CYCLES +
              (ns + 16'(CLK_PERIOD_NS - 1)) / 16'(CLK_PERIOD_NS));
  endfunction : gap_cycles

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == ADDR_POLARITY) || (a == ADDR_CONTROL) ||
           (a == ADDR_INTERVAL) || (a == ADDR_STATUS);
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic        ale_q, next_ale_q;
  logic [7:0]  lat_addr, next_lat_addr;
  logic        lat_cs_n, next_lat_cs_n;
  ubdma_bus_t  bus_st, next_bus_st;
  logic        cyc_dma, next_cyc_dma;
  logic [7:0]  cyc_addr, next_cyc_addr;
  logic [7:0]  pol, next_pol;
  logic [7:0]  ctl, next_ctl;
  logic [7:0]  intv, next_intv;
  logic [15:0] rdata, next_rdata;
  logic        lo_oe_n, next_lo_oe_n;
  logic        hi_oe_n, next_hi_oe_n;
  logic        rx_ready, next_rx_ready;
  logic        tx_ready, next_tx_ready;
  logic        ins_pend, next_ins_pend;
  logic [6:0]  rx_left, next_rx_left;
  logic [6:0]  cnt_lat, next_cnt_lat;
  logic [6:0]  tx_written, next_tx_written;
  logic [8:0]  gap, next_gap;
  logic        dma_request_out_pin, next_dma_request_out_pin;
  ubdma_ep_out_t eo, next_eo;

  // ----------------------------------------------------------------------
  // decode of the current bus cycle
  // ----------------------------------------------------------------------
  logic [7:0] eff_addr;
  logic       eff_cs_n, dma_acknowledge_in_act, dma_sel, reg_sel, wide, two;
  logic       rd_done, wr_done, req_cond, req;
  logic [7:0] tx_sum;

  always_comb begin
    eff_addr = s_fmt ? lat_addr : s_addr;
    eff_cs_n = s_fmt ? lat_cs_n : s_cs_n;
    dma_acknowledge_in_act = s_dma_acknowledge_in ^ pol[POL_DMA_ACKNOWLEDGE_IN_BIT];
    wide     = ctl[CTL_WIDE];
    // dual mode reaches the fifo by address, single mode by acknowledge
    dma_sel  = ctl[CTL_DUAL] ? (!eff_cs_n && eff_addr == ADDR_FIFO)
                             : dma_acknowledge_in_act;
    reg_sel  = !eff_cs_n && !dma_sel;
    two      = wide && (rx_left > 7'h01);
    rd_done  = bus_st == BUS_READ && s_rd_n && cyc_dma;
    wr_done  = bus_st == BUS_WRITE && s_wr_n && cyc_dma;
    tx_sum   = {1'b0, tx_written} + (wide ? 8'h02 : 8'h01);
    // only endpoint one feeds this port, no other endpoint can ask
    req_cond = ctl[CTL_ENABLE] && !ctl[CTL_PAUSE] &&
               (ep_in.dir_in ? (!tx_ready && ep_in.tx_space)
                             : (rx_ready && (ins_pend || rx_left != 7'h00)));
    // demand mode ignores the gap and holds the request
    req      = req_cond && (ctl[CTL_DEMAND] || gap == 9'h000);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_ale_q      = s_ale;
    next_lat_addr   = lat_addr;
    next_lat_cs_n   = lat_cs_n;
    next_bus_st     = bus_st;
    next_cyc_dma    = cyc_dma;
    next_cyc_addr   = cyc_addr;
    next_pol        = pol;
    next_ctl        = ctl;
    next_intv       = intv;
    next_rdata      = rdata;
    next_lo_oe_n    = lo_oe_n;
    next_hi_oe_n    = hi_oe_n;
    next_rx_ready   = rx_ready;
    next_tx_ready   = tx_ready;
    next_ins_pend   = ins_pend;
    next_rx_left    = rx_left;
    next_cnt_lat    = cnt_lat;
    next_tx_written = tx_written;
    next_gap        = (gap != 9'h000) ? gap - 9'h001 : gap;
    next_eo         = eo;
    next_eo.tx_push    = 1'b0;
    next_eo.rx_pop     = 1'b0;
    next_eo.rx_drained = 1'b0;

    // address phase on the trailing edge of the latch strobe
    if (s_fmt && ale_q && !s_ale) begin
      next_lat_addr = s_lo;
      next_lat_cs_n = s_cs_n;
    end

    // bus cycle tracking
    unique case (bus_st)
      BUS_IDLE: begin
        if (!s_rd_n && (dma_sel || reg_sel)) begin
          next_bus_st   = BUS_READ;
          next_cyc_dma  = dma_sel;
          next_cyc_addr = eff_addr;
          next_lo_oe_n  = 1'b0;
          next_hi_oe_n  = !(dma_sel && wide);
          if (dma_sel) begin
            if (ins_pend)
              next_rdata = {8'h00, 1'b0, cnt_lat};
            else
              next_rdata = {two ? ep_in.rx_head_hi : 8'h00,
                            ep_in.rx_head_lo};
          end else begin
            unique case (eff_addr)
              ADDR_POLARITY: next_rdata = {8'h00, pol};
              ADDR_CONTROL:  next_rdata = {8'h00, ctl};
              ADDR_INTERVAL: next_rdata = {8'h00, intv};
              ADDR_STATUS:   next_rdata = {8'h00, 4'h0, ctl[CTL_PAUSE],
                                           dma_request_out_pin ~^ pol[POL_DMA_REQUEST_OUT_BIT],
                                           tx_ready, rx_ready};
              default:       next_rdata = 16'h0000;
            endcase
          end
        end else if (!s_wr_n && (dma_sel || reg_sel)) begin
          next_bus_st   = BUS_WRITE;
          next_cyc_dma  = dma_sel;
          next_cyc_addr = eff_addr;
        end
      end
      BUS_READ: begin
        if (s_rd_n) begin
          next_bus_st  = BUS_IDLE;
          next_lo_oe_n = 1'b1;
          next_hi_oe_n = 1'b1;
        end
      end
      BUS_WRITE: begin
        if (s_wr_n) begin
          next_bus_st = BUS_IDLE;
          if (!cyc_dma && reg_hit(cyc_addr)) begin
            unique case (cyc_addr)
              ADDR_POLARITY: next_pol  = s_lo;
              ADDR_CONTROL:  next_ctl  = s_lo;
              ADDR_INTERVAL: next_intv = s_lo;
              default:       next_pol  = pol;
            endcase
          end
        end
      end
      default: next_bus_st = BUS_IDLE;
    endcase

    // receive side: consume count word or data at the end of each dma read
    if (rd_done) begin
      if (ins_pend) begin
        next_ins_pend = 1'b0;
      end else begin
        next_eo.rx_pop = 1'b1;
        next_eo.rx_two = two;
        next_rx_left   = rx_left - (two ? 7'h02 : 7'h01);
      end
    end
    if (rx_ready && !ins_pend && rx_left == 7'h00) begin
      next_rx_ready      = 1'b0;
      next_eo.rx_drained = 1'b1;
    end
    // a new packet outranks the drain of the old one
    if (ep_in.rx_good) begin
      next_rx_ready = 1'b1;
      next_rx_left  = ep_in.rx_count;
      next_cnt_lat  = ep_in.rx_count;
      next_ins_pend = ctl[CTL_COUNT];
    end

    // transmit side
    if (wr_done) begin
      next_eo.tx_push = 1'b1;
      next_eo.tx_two  = wide;
      next_eo.tx_data = {wide ? s_hi : 8'h00, s_lo};
      next_tx_written = tx_sum[6:0];
    end
    if (ep_in.tx_acked)
      next_tx_ready = 1'b0;
    if (wr_done && tx_sum >= {1'b0, MAX_PKT}) begin
      next_tx_ready   = 1'b1;
      next_tx_written = 7'h00;
    end
    if (ep_in.tx_mcu_set) begin
      next_tx_ready   = 1'b1;
      next_tx_written = 7'h00;
    end

    // single mode: each finished transfer opens a quiet gap
    if ((rd_done || wr_done) && !ctl[CTL_DEMAND])
      next_gap = gap_cycles(intv);

    next_dma_request_out_pin = req ~^ pol[POL_DMA_REQUEST_OUT_BIT];
    next_eo.tx_ready = next_tx_ready;
    next_eo.rx_ready = next_rx_ready;

    // software reset returns registers, flags and bus state to power-up values; address latch keeps its value
    if (sw_reset) begin
      next_pol        = POLARITY_RST;
      next_ctl        = CONTROL_RST;
      next_intv       = INTERVAL_RST;
      next_bus_st     = BUS_IDLE;
      next_lo_oe_n    = 1'b1;
      next_hi_oe_n    = 1'b1;
      next_rdata      = 16'h0000;
      next_rx_ready   = 1'b0;
      next_tx_ready   = 1'b0;
      next_ins_pend   = 1'b0;
      next_rx_left    = 7'h00;
      next_tx_written = 7'h00;
      next_gap        = 9'h000;
      next_dma_request_out_pin   = 1'b1;
      next_eo         = '0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_q      <= 1'b0;
      lat_addr   <= 8'h00;
      lat_cs_n   <= 1'b1;
      bus_st     <= BUS_IDLE;
      cyc_dma    <= 1'b0;
      cyc_addr   <= 8'h00;
      pol        <= POLARITY_RST;
      ctl        <= CONTROL_RST;
      intv       <= INTERVAL_RST;
      rdata      <= 16'h0000;
      lo_oe_n    <= 1'b1;
      hi_oe_n    <= 1'b1;
      rx_ready   <= 1'b0;
      tx_ready   <= 1'b0;
      ins_pend   <= 1'b0;
      rx_left    <= 7'h00;
      cnt_lat    <= 7'h00;
      tx_written <= 7'h00;
      gap        <= 9'h000;
      dma_request_out_pin   <= 1'b1;
      eo         <= '0;
    end else begin
      ale_q      <= next_ale_q;
      lat_addr   <= next_lat_addr;
      lat_cs_n   <= next_lat_cs_n;
      bus_st     <= next_bus_st;
      cyc_dma    <= next_cyc_dma;
      cyc_addr   <= next_cyc_addr;
      pol        <= next_pol;
      ctl        <= next_ctl;
      intv       <= next_intv;
      rdata      <= next_rdata;
      lo_oe_n    <= next_lo_oe_n;
      hi_oe_n    <= next_hi_oe_n;
      rx_ready   <= next_rx_ready;
      tx_ready   <= next_tx_ready;
      ins_pend   <= next_ins_pend;
      rx_left    <= next_rx_left;
      cnt_lat    <= next_cnt_lat;
      tx_written <= next_tx_written;
      gap        <= next_gap;
      dma_request_out_pin   <= next_dma_request_out_pin;
      eo         <= next_eo;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign shared_low_byte_lines_out  = rdata[7:0];
  assign upper_data_lines_out       = rdata[15:8];
  assign shared_low_byte_lines_oe_n = lo_oe_n;
  assign upper_data_lines_oe_n      = hi_oe_n;
  assign dma_request_out            = dma_request_out_pin;
  assign ep_out                     = eo;

endmodule : ubdma_port
`default_nettype wire

/* File: verif/ubdma_port_properties.sv */
// Purpose: port level assertions for the bulk endpoint dma port
// Assumes: single clock, asynchronous active high reset
// Notes:   sees only top ports, so checks are relations between pins
`timescale 1ns/10ps
`default_nettype none
module ubdma_port_properties
  import ubdma_pkg::*;
(
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          sw_reset,
  input wire logic          read_n,
  input wire logic          shared_low_byte_lines_oe_n,
  input wire logic          upper_data_lines_oe_n,
  input wire logic          dma_request_out,
  input wire ubdma_ep_in_t  ep_in,
  input wire ubdma_ep_out_t ep_out
);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_swrst_idle: assert property (
    sw_reset |=> dma_request_out && shared_low_byte_lines_oe_n)
    else $error("request or bus active after soft reset");
  a_read_cause: assert property (
    $fell(shared_low_byte_lines_oe_n)
      |-> !$past(read_n, 2) && !$past(read_n, 3))
    else $error("low lines driven without a read strobe");
  a_read_release: assert property (
    $rose(read_n) |-> ##[1:5] shared_low_byte_lines_oe_n)
    else $error("low lines still driven after read ended");
  a_idle_quiet: assert property (
    read_n [*6] |-> shared_low_byte_lines_oe_n)
    else $error("low lines driven while no read");
  a_upper_pair: assert property (
    !upper_data_lines_oe_n |-> !shared_low_byte_lines_oe_n)
    else $error("upper byte driven without low byte");
  a_rx_set: assert property (
    ep_in.rx_good |=> ep_out.rx_ready)
    else $error("receive ready not set by good packet");
  a_rx_clear: assert property (
    ep_out.rx_drained |-> !ep_out.rx_ready || $past(ep_in.rx_good))
    else $error("receive ready kept after drain");
  a_tx_set: assert property (
    ep_in.tx_mcu_set |=> ep_out.tx_ready)
    else $error("transmit ready not set");
  a_tx_clear: assert property (
    ep_in.tx_acked && !ep_in.tx_mcu_set
      |=> !ep_out.tx_ready || ep_out.tx_push)
    else $error("transmit ready not cleared by host ack");
  a_pop_after: assert property (
    ep_out.rx_pop |-> read_n && $past(read_n) ##1 !ep_out.rx_pop)
    else $error("fifo pop before strobe release or repeated");

  c_pop_two:   cover property (ep_out.rx_pop && ep_out.rx_two);
  c_tx_ack:    cover property (ep_in.tx_acked && ep_out.tx_ready);
  c_upper_drv: cover property (!upper_data_lines_oe_n);
endmodule : ubdma_port_properties

bind ubdma_port ubdma_port_properties ubdma_port_properties_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .sw_reset(sw_reset),
  .read_n(read_n),
  .shared_low_byte_lines_oe_n(shared_low_byte_lines_oe_n),
  .upper_data_lines_oe_n(upper_data_lines_oe_n),
  .dma_request_out(dma_request_out),
  .ep_in(ep_in),
  .ep_out(ep_out)
);
`default_nettype wire

/* File: verif/ubdma_dma_model.sv */
// Purpose: external dma controller, single address reads
// Assumes: request active low, acknowledge active high (reset polarities)
// Notes:   fixed strobe length; data taken at the same edge that releases the strobe
`timescale 1ns/10ps
`default_nettype none
module ubdma_dma_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic        dma_request_out,
  input  wire logic [15:0] rd_data,
  output var  logic        dma_rd_n,
  output var  logic        dma_ack,
  output var  logic [15:0] last,
  output var  int          xfers
);
  int ph;
  // one read per look; looks again 16 cycles after the last look, so demand mode keeps the bus
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph       <= 0;
      dma_rd_n <= 1'b1;
      dma_ack  <= 1'b0;
      last     <= 16'h0000;
      xfers    <= 0;
    end else begin
      ph <= (ph == 0) ? ((run && !dma_request_out) ? 1 : 0) : (ph + 1) % 16;
      if (ph == 0 && run && !dma_request_out) begin
        dma_ack  <= 1'b1;
        dma_rd_n <= 1'b0;
      end
      if (ph == 6) begin
        last     <= rd_data;
        xfers    <= xfers + 1;
        dma_rd_n <= 1'b1;
      end
      // acknowledge outlives the strobe so the end of read is selected
      if (ph == 11) dma_ack <= 1'b0;
    end
  end
endmodule : ubdma_dma_model
`default_nettype wire

/* File: verif/ubdma_port_tb.sv */
// Purpose: self-checking bench for the bulk endpoint dma port
// Assumes: bench plays processor bus and endpoint fifo, model plays dma
// Notes:   reset polarities unless a test changes them
`timescale 1ns/10ps
`default_nettype none
module ubdma_port_tb
  import ubdma_pkg::*;
;
  localparam logic [7:0] RXQ [4] = '{8'ha5, 8'h3c, 8'h96, 8'hff};
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          sw_reset = 1'b0;
  logic          fmt = 1'b0;
  logic [7:0]    ded = 8'h00;
  logic [7:0]    sh_tb = 8'h00;
  logic          cs_n = 1'b1;
  logic          rd_n = 1'b1;
  logic          wr_n = 1'b1;
  logic          ale = 1'b0;
  logic          run = 1'b0;
  logic [1:0]    ptr = 2'd0;
  ubdma_ep_in_t  epi;
  ubdma_ep_out_t epo;
  logic [7:0]    lo_out, hi_out;
  logic          lo_oe_n, hi_oe_n, req, drd_n, ack;
  logic [15:0]   last;
  int            xfers, idle, last_gap, cycles, checks, fail_count;
  wire logic [7:0] lo = lo_oe_n ? sh_tb : lo_out;
  wire logic [7:0] hi = hi_oe_n ? 8'h5a : hi_out;

  ubdma_port ubdma_port_i (.clk(clk), .sys_rst(sys_rst), .sw_reset(sw_reset),
    .bus_format_select(fmt), .dedicated_address_pins(ded),
    .shared_low_byte_lines_in(lo), .shared_low_byte_lines_out(lo_out),
    .shared_low_byte_lines_oe_n(lo_oe_n), .upper_data_lines_in(hi),
    .upper_data_lines_out(hi_out), .upper_data_lines_oe_n(hi_oe_n),
    .chip_select_n(cs_n), .read_n(rd_n & drd_n), .write_n(wr_n),
    .address_latch(ale), .dma_acknowledge_in(ack), .dma_request_out(req),
    .ep_in(epi), .ep_out(epo));
  ubdma_dma_model ubdma_dma_model_i (.clk(clk), .sys_rst(sys_rst), .run(run),
    .dma_request_out(req), .rd_data({hi, lo}), .dma_rd_n(drd_n),
    .dma_ack(ack), .last(last), .xfers(xfers));

  // ----------------------------------------------------------------------
  // clock, show-ahead fifo, idle-run meter, time limit
  // ----------------------------------------------------------------------
  always #50 clk = ~clk;
  always @(ptr or sys_rst) begin
    epi.rx_head_lo = RXQ[ptr];
    epi.rx_head_hi = RXQ[ptr + 2'd1];
  end
  always @(posedge clk) begin
    if (epo.rx_pop) ptr <= ptr + (epo.rx_two ? 2'd2 : 2'd1);
    idle <= (req === 1'b1) ? idle + 1 : 0;
    if (req === 1'b0 && idle != 0) last_gap <= idle;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // latch always strobed; unused address lines carry junk
  task automatic bus(input logic wr, input logic [7:0] a, d,
                     output logic [15:0] q);
    @(posedge clk);
    ded   <= fmt ? ~a : a;
    sh_tb <= fmt ? a : ~a;
    cs_n  <= 1'b0;
    ale   <= 1'b1;
    repeat (3) @(posedge clk);
    ale   <= 1'b0;
    repeat (3) @(posedge clk);
    sh_tb <= d;
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk) q = {hi, lo};
    @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : bus
  task automatic cfg(input logic [7:0] ctl);
    logic [15:0] q;
    @(posedge clk) sw_reset <= 1'b1;
    @(posedge clk) sw_reset <= 1'b0;
    bus(1'b1, ADDR_INTERVAL, 8'h03, q);
    bus(1'b1, ADDR_CONTROL, ctl, q);
  endtask : cfg
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 40 && req !== lvl; i++) @(negedge clk);
    check("request", {15'h0, req}, {15'h0, lvl});
  endtask : wait_req
  task automatic take(input int n, input logic [15:0] exp, mask);
    for (int i = 0; i < 400 && xfers < n; i++) @(negedge clk);
    check("dma data", last & mask, exp);
  endtask : take
  task automatic rx_pkt(input logic [6:0] n);
    @(posedge clk);
    epi.rx_good  <= 1'b1;
    epi.rx_count <= n;
    ptr          <= 2'd0;
    @(posedge clk) epi.rx_good <= 1'b0;
  endtask : rx_pkt

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] q;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, ADDR_POLARITY + 8'(i), 8'h00, q);
      check("reset value", {8'h00, q[7:0]}, 16'h0000);
    end
    bus(1'b1, ADDR_INTERVAL, 8'h05, q);
    bus(1'b0, ADDR_INTERVAL, 8'h00, q);
    check("interval", {8'h00, q[7:0]}, 16'h0005);
    bus(1'b0, 8'h3f, 8'h00, q);
    check("unmapped", {8'h00, q[7:0]}, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mux;
    logic [15:0] q;
    @(posedge clk) fmt <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_INTERVAL, 8'h00, q);
    check("mux read", {8'h00, q[7:0]}, 16'h0005);
    bus(1'b1, ADDR_INTERVAL, 8'h00, q);
    bus(1'b0, ADDR_INTERVAL, 8'h00, q);
    check("mux write", {8'h00, q[7:0]}, 16'h0000);
    @(posedge clk) fmt <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test mux done");
  endtask : t_mux
  task automatic t_tx;
    logic [15:0] q;
    @(posedge clk) {epi.dir_in, epi.tx_space} <= 2'b11;
    repeat (10) @(posedge clk);
    wait_req(1'b1);
    cfg(8'h0b);
    wait_req(1'b0);
    bus(1'b1, ADDR_FIFO, 8'h77, q);
    check("tx data", epo.tx_data, 16'h5a77);
    @(posedge clk) epi.tx_mcu_set <= 1'b1;
    @(posedge clk) epi.tx_mcu_set <= 1'b0;
    wait_req(1'b1);
    check("tx ready", {15'h0, epo.tx_ready}, 16'h0001);
    bus(1'b1, ADDR_POLARITY, 8'h02, q);
    wait_req(1'b0);
    bus(1'b1, ADDR_POLARITY, 8'h00, q);
    @(posedge clk) epi.tx_acked <= 1'b1;
    @(posedge clk) epi.tx_acked <= 1'b0;
    wait_req(1'b0);
    check("tx ready", {15'h0, epo.tx_ready}, 16'h0000);
    @(posedge clk) {epi.dir_in, epi.tx_space} <= 2'b00;
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx8;
    int b;
    cfg(8'h05);
    b = xfers;
    run <= 1'b1;
    rx_pkt(7'd2);
    take(b + 1, 16'h0002, 16'h00ff);
    take(b + 2, 16'h00a5, 16'h00ff);
    check("gap", {15'h0, last_gap >= 4 && last_gap <= 9}, 16'h1);
    take(b + 3, 16'h003c, 16'h00ff);
    wait_req(1'b1);
    check("rx ready", {15'h0, epo.rx_ready}, 16'h0000);
    run <= 1'b0;
    $display("test rx8 done");
  endtask : t_rx8
  task automatic t_rx16;
    int b;
    cfg(8'h1d);
    b = xfers;
    run <= 1'b1;
    rx_pkt(7'd3);
    take(b + 1, 16'h0003, 16'hffff);
    take(b + 2, 16'h3ca5, 16'hffff);
    take(b + 3, 16'h0096, 16'hffff);
    wait_req(1'b1);
    check("dma count", 16'(xfers - b), 16'h0003);
    run <= 1'b0;
    $display("test rx16 done");
  endtask : t_rx16
  task automatic t_pause;
    logic [15:0] q;
    int b;
    cfg(8'h01);
    b = xfers;
    rx_pkt(7'd2);
    wait_req(1'b0);
    bus(1'b1, ADDR_CONTROL, 8'h81, q);
    wait_req(1'b1);
    bus(1'b1, ADDR_CONTROL, 8'h01, q);
    wait_req(1'b0);
    run <= 1'b1;
    take(b + 1, 16'h00a5, 16'h00ff);
    take(b + 2, 16'h003c, 16'h00ff);
    wait_req(1'b1);
    run <= 1'b0;
    $display("test pause done");
  endtask : t_pause

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  initial begin
    {epi.dir_in, epi.tx_space, epi.tx_acked, epi.tx_mcu_set} = 4'h0;
    {epi.rx_good, epi.rx_count} = 8'h00;
    {idle, last_gap, cycles, checks, fail_count} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs;
    t_mux;
    t_tx;
    t_rx8;
    t_rx16;
    t_pause;
    end_sim;
  end
endmodule : ubdma_port_tb
`default_nettype wire
